//--- rtl/ftu_down_counter.sv
// Down counter with reload latch and underflow pulse
`timescale 1ns/1ps
module ftu_down_counter #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // Control
    input wire logic tick_in,
    input wire logic wr_both_in,
    input wire logic wr_latch_in,
    input wire logic reload_in,
    input wire logic [W-1:0] data_in,
    // Status
    output logic [W-1:0] count_out,
    output logic uf_out
);

    typedef struct packed {
        logic [W-1:0] count;
        logic [W-1:0] latch;
    } ftu_cnt_state_t;

    ftu_cnt_state_t s_r;
    ftu_cnt_state_t s_nxt;

    // Next count and latch
    always_comb begin
        s_nxt = s_r;
        uf_out = tick_in && (s_r.count == '0);
        if (wr_both_in || wr_latch_in) begin
            s_nxt.latch = data_in;
        end
        if (wr_both_in) begin
            s_nxt.count = data_in;
        end else if (uf_out || reload_in) begin
            s_nxt.count = s_nxt.latch;
        end else if (tick_in) begin
            s_nxt.count = s_r.count - 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_r <= {RST_VAL, RST_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign count_out = s_r.count;

endmodule // ftu_down_counter

//--- rtl/ftu_pkg.sv
// Package of constants and types for the five-timer unit
package ftu_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [4:0] FTU_OFF_TX_LO = 5'h00;
    localparam logic [4:0] FTU_OFF_TX_HI = 5'h01;
    localparam logic [4:0] FTU_OFF_TY_LO = 5'h02;
    localparam logic [4:0] FTU_OFF_TY_HI = 5'h03;
    localparam logic [4:0] FTU_OFF_T1 = 5'h04;
    localparam logic [4:0] FTU_OFF_T2 = 5'h05;
    localparam logic [4:0] FTU_OFF_T3 = 5'h06;
    localparam logic [4:0] FTU_OFF_TX_MODE = 5'h07;
    localparam logic [4:0] FTU_OFF_TY_MODE = 5'h08;
    localparam logic [4:0] FTU_OFF_T123_MODE = 5'h09;
    localparam logic [4:0] FTU_OFF_IRQ = 5'h0A;

    // ****************************************************************
    // Request flag positions
    // ****************************************************************
    localparam int FTU_IRQ_TX = 0;
    localparam int FTU_IRQ_TY = 1;
    localparam int FTU_IRQ_T1 = 2;
    localparam int FTU_IRQ_T2 = 3;
    localparam int FTU_IRQ_T3 = 4;
    localparam int FTU_IRQ_PIN0 = 5;
    localparam int FTU_IRQ_PIN1 = 6;
    localparam int FTU_IRQ_W = 7;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] FTU_RST_MODE = 8'h00;
    localparam logic [15:0] FTU_RST_WIDE = 16'hFFFF;
    localparam logic [7:0] FTU_RST_BYTE = 8'hFF;
    localparam logic [FTU_IRQ_W-1:0] FTU_RST_IRQ = 7'h00;
    localparam logic FTU_RST_PIN_LVL = 1'b1;
    localparam logic FTU_RST_OE_N = 1'b1;

    // ****************************************************************
    // Timing counts
    // ****************************************************************
    localparam int FTU_PRE_W = 6;
    localparam logic [FTU_PRE_W-1:0] FTU_PRE_MASK_8 = 6'h07;
    localparam logic [FTU_PRE_W-1:0] FTU_PRE_MASK_16 = 6'h0F;
    localparam logic [FTU_PRE_W-1:0] FTU_PRE_MASK_32 = 6'h1F;
    localparam logic [FTU_PRE_W-1:0] FTU_PRE_MASK_64 = 6'h3F;

    // ****************************************************************
    // Modes and register layouts
    // ****************************************************************
    typedef enum logic [1:0] {
        FTU_XM_TIMER = 2'b00,
        FTU_XM_PULSE = 2'b01,
        FTU_XM_EVENT = 2'b10,
        FTU_XM_WIDTH = 2'b11
    } ftu_xmode_t;

    typedef enum logic [1:0] {
        FTU_YM_TIMER = 2'b00,
        FTU_YM_PERIOD = 2'b01,
        FTU_YM_EVENT = 2'b10,
        FTU_YM_HL = 2'b11
    } ftu_ymode_t;

    typedef struct packed {
        logic src_special;
        logic [1:0] div;
        logic stop;
        logic edge_sel;
        logic wctl;
        ftu_xmode_t mode;
    } ftu_xreg_t;

    typedef struct packed {
        logic [1:0] div;
        logic out_en;
        logic rsvd;
        logic edge_sel;
        logic wctl;
        ftu_ymode_t mode;
    } ftu_yreg_t;

    typedef struct packed {
        logic rsvd;
        logic t3_div;
        logic t2_div;
        logic t1_special;
        logic wctl;
        logic out_en;
        logic edge_sel;
        logic factor_t2;
    } ftu_breg_t;

endpackage

//--- rtl/ftu_timer_unit.sv
// Five-timer unit: two wide and three byte down counters
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module ftu_timer_unit (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // Register port
    input wire logic [4:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // Interrupt requests and acceptance
    input wire logic [ftu_pkg::FTU_IRQ_W-1:0] irq_ack_in,
    output logic [ftu_pkg::FTU_IRQ_W-1:0] irq_req_out,
    // Count source pin
    input wire logic special_count_clock_in,
    // First wide timer pin
    input wire logic ext_pin_first_wide_timer_in,
    output logic ext_pin_first_wide_timer_out,
    output logic ext_pin_first_wide_timer_oe_n_out,
    // Second wide timer pin
    input wire logic ext_pin_second_wide_timer_in,
    output logic second_wide_toggle_out,
    output logic second_wide_toggle_oe_n_out,
    // Byte timer toggle pin
    output logic byte_toggle_out,
    output logic byte_toggle_oe_n_out
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        ftu_pkg::ftu_xreg_t xmode;
        ftu_pkg::ftu_yreg_t ymode;
        ftu_pkg::ftu_breg_t bmode;
        logic [7:0] x_wr_lo;
        logic [7:0] y_wr_lo;
        logic [7:0] x_rd_lo;
        logic [7:0] y_rd_lo;
        logic [15:0] y_cap;
        logic y_cap_vld;
        logic [ftu_pkg::FTU_IRQ_W-1:0] irq;
        logic x_lvl;
        logic y_lvl;
        logic b_lvl;
        logic x_oe_n;
        logic y_oe_n;
        logic b_oe_n;
        logic [ftu_pkg::FTU_PRE_W-1:0] pre;
        logic [2:0] sc_sync;
        logic [2:0] x_sync;
        logic [2:0] y_sync;
        logic [7:0] rdata;
    } ftu_state_t;

    ftu_state_t s_r;
    ftu_state_t s_nxt;

    // ****************************************************************
    // Counter wiring
    // ****************************************************************
    logic x_tick;
    logic x_wr_both;
    logic x_wr_latch;
    logic [15:0] x_cnt;
    logic x_uf;
    logic y_tick;
    logic y_wr_both;
    logic y_wr_latch;
    logic y_reload;
    logic [15:0] y_cnt;
    logic y_uf;
    logic [2:0] b_tick;
    logic [2:0] b_wr_both;
    logic [2:0] b_wr_latch;
    logic [7:0] b_cnt [3];
    logic [2:0] b_uf;

    // Prescaler tick for the divider select
    function automatic logic div_tick(input logic [1:0] sel,
                                      input logic [ftu_pkg::FTU_PRE_W-1:0] pre);
        logic [ftu_pkg::FTU_PRE_W-1:0] mask;
        mask = ftu_pkg::FTU_PRE_MASK_8;
        case (sel)
            2'h0: mask = ftu_pkg::FTU_PRE_MASK_8;
            2'h1: mask = ftu_pkg::FTU_PRE_MASK_16;
            2'h2: mask = ftu_pkg::FTU_PRE_MASK_32;
            2'h3: mask = ftu_pkg::FTU_PRE_MASK_64;
            default: mask = ftu_pkg::FTU_PRE_MASK_8;
        endcase
        return (pre & mask) == mask;
    endfunction

    // Write strobe for one offset
    function automatic logic hit(input logic strobe, input logic [4:0] addr,
                                 input logic [4:0] off);
        return strobe && (addr == off);
    endfunction

    // ****************************************************************
    // Counters
    // ****************************************************************
    ftu_down_counter #(.W(16), .RST_VAL(ftu_pkg::FTU_RST_WIDE)) u_cnt_x (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .tick_in(x_tick),
        .wr_both_in(x_wr_both),
        .wr_latch_in(x_wr_latch),
        .reload_in(1'b0),
        .data_in({wdata_in, s_r.x_wr_lo}),
        .count_out(x_cnt),
        .uf_out(x_uf)
    );

    ftu_down_counter #(.W(16), .RST_VAL(ftu_pkg::FTU_RST_WIDE)) u_cnt_y (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .tick_in(y_tick),
        .wr_both_in(y_wr_both),
        .wr_latch_in(y_wr_latch),
        .reload_in(y_reload),
        .data_in({wdata_in, s_r.y_wr_lo}),
        .count_out(y_cnt),
        .uf_out(y_uf)
    );

    // Three byte timers
    for (genvar i = 0; i < 3; i++) begin : g_byte
        ftu_down_counter #(.W(8), .RST_VAL(ftu_pkg::FTU_RST_BYTE)) u_cnt_b (
            .ref_clk_in(ref_clk_in),
            .resetn_in(resetn_in),
            .tick_in(b_tick[i]),
            .wr_both_in(b_wr_both[i]),
            .wr_latch_in(b_wr_latch[i]),
            .reload_in(1'b0),
            .data_in(wdata_in),
            .count_out(b_cnt[i]),
            .uf_out(b_uf[i])
        );
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic sc_rise;
        logic x_rise;
        logic x_fall;
        logic y_rise;
        logic y_fall;
        logic x_src;
        logic x_pin_ev;
        logic y_pin_ev;
        logic y_meas_ev;
        logic div8;
        logic b_sel_uf;
        logic [ftu_pkg::FTU_IRQ_W-1:0] ev;
        s_nxt = s_r;
        sc_rise = 1'b0;
        x_rise = 1'b0;
        x_fall = 1'b0;
        y_rise = 1'b0;
        y_fall = 1'b0;
        x_src = 1'b0;
        x_pin_ev = 1'b0;
        y_pin_ev = 1'b0;
        y_meas_ev = 1'b0;
        div8 = 1'b0;
        b_sel_uf = 1'b0;
        ev = '0;
        x_tick = 1'b0;
        y_tick = 1'b0;
        b_tick = '0;

        // Prescaler and pin synchronisers, third stage for edges
        s_nxt.pre = s_r.pre + 1'b1;
        s_nxt.sc_sync = {s_r.sc_sync[1:0], special_count_clock_in};
        s_nxt.x_sync = {s_r.x_sync[1:0], ext_pin_first_wide_timer_in};
        s_nxt.y_sync = {s_r.y_sync[1:0], ext_pin_second_wide_timer_in};
        sc_rise = s_r.sc_sync[1] && !s_r.sc_sync[2];
        x_rise = s_r.x_sync[1] && !s_r.x_sync[2];
        x_fall = !s_r.x_sync[1] && s_r.x_sync[2];
        y_rise = s_r.y_sync[1] && !s_r.y_sync[2];
        y_fall = !s_r.y_sync[1] && s_r.y_sync[2];
        div8 = div_tick(2'h0, s_r.pre);

        // First wide timer count pulse
        x_src = s_r.xmode.src_special ? sc_rise
                                      : div_tick(s_r.xmode.div, s_r.pre);
        x_pin_ev = s_r.xmode.edge_sel ? x_fall : x_rise;
        case (s_r.xmode.mode)
            ftu_pkg::FTU_XM_TIMER: x_tick = x_src;
            ftu_pkg::FTU_XM_PULSE: x_tick = x_src;
            ftu_pkg::FTU_XM_EVENT: x_tick = x_pin_ev;
            ftu_pkg::FTU_XM_WIDTH: x_tick = x_src && (s_r.x_sync[1] != s_r.xmode.edge_sel);
            default: x_tick = 1'b0;
        endcase
        x_tick = x_tick && !s_r.xmode.stop;

        // Second wide timer count pulse and measurement edge
        y_pin_ev = s_r.ymode.edge_sel ? y_fall : y_rise;
        case (s_r.ymode.mode)
            ftu_pkg::FTU_YM_TIMER: y_tick = div_tick(s_r.ymode.div, s_r.pre);
            ftu_pkg::FTU_YM_PERIOD: begin
                y_tick = div_tick(s_r.ymode.div, s_r.pre);
                y_meas_ev = s_r.ymode.edge_sel ? y_rise : y_fall;
            end
            ftu_pkg::FTU_YM_EVENT: y_tick = y_pin_ev;
            ftu_pkg::FTU_YM_HL: begin
                y_tick = div_tick(s_r.ymode.div, s_r.pre);
                y_meas_ev = y_rise || y_fall;
            end
            default: y_tick = 1'b0;
        endcase
        y_reload = y_meas_ev;

        // Byte timer sources
        b_tick[0] = s_r.bmode.t1_special ? sc_rise : div8;
        b_tick[1] = s_r.bmode.t2_div ? div8 : b_uf[0];
        b_tick[2] = s_r.bmode.t3_div ? div8 : b_uf[0];

        // Counter writes: wide high byte commits both bytes
        x_wr_both = hit(wr_in, addr_in, ftu_pkg::FTU_OFF_TX_HI) && !s_r.xmode.wctl;
        x_wr_latch = hit(wr_in, addr_in, ftu_pkg::FTU_OFF_TX_HI) && s_r.xmode.wctl;
        y_wr_both = hit(wr_in, addr_in, ftu_pkg::FTU_OFF_TY_HI) && !s_r.ymode.wctl;
        y_wr_latch = hit(wr_in, addr_in, ftu_pkg::FTU_OFF_TY_HI) && s_r.ymode.wctl;
        for (int i = 0; i < 2; i++) begin
            b_wr_both[i] = hit(wr_in, addr_in, ftu_pkg::FTU_OFF_T1 + 5'(i))
                           && !s_r.bmode.wctl;
            b_wr_latch[i] = hit(wr_in, addr_in, ftu_pkg::FTU_OFF_T1 + 5'(i))
                            && s_r.bmode.wctl;
        end
        b_wr_both[2] = hit(wr_in, addr_in, ftu_pkg::FTU_OFF_T3);
        b_wr_latch[2] = 1'b0;
        if (hit(wr_in, addr_in, ftu_pkg::FTU_OFF_TX_LO)) begin
            s_nxt.x_wr_lo = wdata_in;
        end
        if (hit(wr_in, addr_in, ftu_pkg::FTU_OFF_TY_LO)) begin
            s_nxt.y_wr_lo = wdata_in;
        end

        // Pin toggles on underflow
        if ((s_r.xmode.mode == ftu_pkg::FTU_XM_PULSE) && x_uf) begin
            s_nxt.x_lvl = !s_r.x_lvl;
        end
        if ((s_r.ymode.mode == ftu_pkg::FTU_YM_TIMER) && s_r.ymode.out_en && y_uf) begin
            s_nxt.y_lvl = !s_r.y_lvl;
        end
        b_sel_uf = s_r.bmode.factor_t2 ? b_uf[1] : b_uf[0];
        if (s_r.bmode.out_en && b_sel_uf) begin
            s_nxt.b_lvl = !s_r.b_lvl;
        end

        // Mode writes restart the pin at its start level
        if (hit(wr_in, addr_in, ftu_pkg::FTU_OFF_TX_MODE)) begin
            s_nxt.xmode = ftu_pkg::ftu_xreg_t'(wdata_in);
            s_nxt.x_lvl = !s_nxt.xmode.edge_sel;
        end
        if (hit(wr_in, addr_in, ftu_pkg::FTU_OFF_TY_MODE)) begin
            s_nxt.ymode = ftu_pkg::ftu_yreg_t'(wdata_in);
            s_nxt.ymode.rsvd = 1'b0;
            s_nxt.y_lvl = !s_nxt.ymode.edge_sel;
        end
        if (hit(wr_in, addr_in, ftu_pkg::FTU_OFF_T123_MODE)) begin
            s_nxt.bmode = ftu_pkg::ftu_breg_t'(wdata_in);
            s_nxt.bmode.rsvd = 1'b0;
            s_nxt.b_lvl = !s_nxt.bmode.edge_sel;
        end
        s_nxt.x_oe_n = !(s_nxt.xmode.mode == ftu_pkg::FTU_XM_PULSE);
        s_nxt.y_oe_n = !((s_nxt.ymode.mode == ftu_pkg::FTU_YM_TIMER)
                         && s_nxt.ymode.out_en);
        s_nxt.b_oe_n = !s_nxt.bmode.out_en;

        // Register reads, data valid in the next cycle only
        s_nxt.rdata = 8'h00;
        if (rd_in) begin
            case (addr_in)
                ftu_pkg::FTU_OFF_TX_HI: begin
                    s_nxt.rdata = x_cnt[15:8];
                    s_nxt.x_rd_lo = x_cnt[7:0];
                end
                ftu_pkg::FTU_OFF_TX_LO: s_nxt.rdata = s_r.x_rd_lo;
                ftu_pkg::FTU_OFF_TY_HI: begin
                    s_nxt.rdata = s_r.y_cap_vld ? s_r.y_cap[15:8] : y_cnt[15:8];
                    s_nxt.y_rd_lo = s_r.y_cap_vld ? s_r.y_cap[7:0] : y_cnt[7:0];
                end
                ftu_pkg::FTU_OFF_TY_LO: begin
                    s_nxt.rdata = s_r.y_rd_lo;
                    s_nxt.y_cap_vld = 1'b0;
                end
                ftu_pkg::FTU_OFF_T1: s_nxt.rdata = b_cnt[0];
                ftu_pkg::FTU_OFF_T2: s_nxt.rdata = b_cnt[1];
                ftu_pkg::FTU_OFF_T3: s_nxt.rdata = b_cnt[2];
                ftu_pkg::FTU_OFF_TX_MODE: s_nxt.rdata = s_r.xmode;
                ftu_pkg::FTU_OFF_TY_MODE: s_nxt.rdata = s_r.ymode;
                ftu_pkg::FTU_OFF_T123_MODE: s_nxt.rdata = s_r.bmode;
                ftu_pkg::FTU_OFF_IRQ: s_nxt.rdata = {1'b0, s_r.irq};
                default: s_nxt.rdata = 8'h00;
            endcase
        end

        // Capture before an edge reload; a new edge beats a read clear
        if (y_meas_ev) begin
            s_nxt.y_cap = y_cnt;
            s_nxt.y_cap_vld = 1'b1;
        end

        // Request flags: clears first, then events so set wins
        ev[ftu_pkg::FTU_IRQ_TX] = x_uf;
        ev[ftu_pkg::FTU_IRQ_TY] = y_uf;
        ev[ftu_pkg::FTU_IRQ_T1] = b_uf[0];
        ev[ftu_pkg::FTU_IRQ_T2] = b_uf[1];
        ev[ftu_pkg::FTU_IRQ_T3] = b_uf[2];
        ev[ftu_pkg::FTU_IRQ_PIN0] = x_pin_ev;
        ev[ftu_pkg::FTU_IRQ_PIN1] = (s_r.ymode.mode == ftu_pkg::FTU_YM_PERIOD
                                     || s_r.ymode.mode == ftu_pkg::FTU_YM_HL)
                                    ? y_meas_ev : y_pin_ev;
        if (hit(wr_in, addr_in, ftu_pkg::FTU_OFF_IRQ)) begin
            s_nxt.irq = s_nxt.irq & wdata_in[ftu_pkg::FTU_IRQ_W-1:0];
        end
        s_nxt.irq = (s_nxt.irq & ~irq_ack_in) | ev;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_r <= '0;
            s_r.xmode <= ftu_pkg::ftu_xreg_t'(ftu_pkg::FTU_RST_MODE);
            s_r.ymode <= ftu_pkg::ftu_yreg_t'(ftu_pkg::FTU_RST_MODE);
            s_r.bmode <= ftu_pkg::ftu_breg_t'(ftu_pkg::FTU_RST_MODE);
            s_r.irq <= ftu_pkg::FTU_RST_IRQ;
            s_r.x_lvl <= ftu_pkg::FTU_RST_PIN_LVL;
            s_r.y_lvl <= ftu_pkg::FTU_RST_PIN_LVL;
            s_r.b_lvl <= ftu_pkg::FTU_RST_PIN_LVL;
            s_r.x_oe_n <= ftu_pkg::FTU_RST_OE_N;
            s_r.y_oe_n <= ftu_pkg::FTU_RST_OE_N;
            s_r.b_oe_n <= ftu_pkg::FTU_RST_OE_N;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rdata_out = s_r.rdata;
    assign irq_req_out = s_r.irq;
    assign ext_pin_first_wide_timer_out = s_r.x_lvl;
    assign ext_pin_first_wide_timer_oe_n_out = s_r.x_oe_n;
    assign second_wide_toggle_out = s_r.y_lvl;
    assign second_wide_toggle_oe_n_out = s_r.y_oe_n;
    assign byte_toggle_out = s_r.b_lvl;
    assign byte_toggle_oe_n_out = s_r.b_oe_n;

endmodule // ftu_timer_unit

//--- sim/ftu_pin_model.sv
// Far-side pulse source for the timer pins
`timescale 1ns/1ps
module ftu_pin_model (
    // Clock and control
    input wire logic ref_clk_in,
    input wire logic run_in,
    // Pin levels
    output logic [2:0] pin_out
);
    logic [5:0] cnt_r = 6'h00;
    // Free counter sets three pulse rates
    always_ff @(posedge ref_clk_in) begin
        cnt_r <= cnt_r + 6'h01;
    end
    // Pins rest low between bursts
    assign pin_out = run_in ? cnt_r[5:3] : 3'b000;
endmodule // ftu_pin_model

//--- sim/ftu_timer_unit_monitor.sv
// Port checker for the five-timer unit
`timescale 1ns/1ps
module ftu_timer_unit_monitor (
    // Clock, reset, register port
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [4:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    // Requests and pins
    input wire logic [6:0] irq_ack_in,
    input wire logic [6:0] irq_req_out,
    input wire logic ext_pin_first_wide_timer_out,
    input wire logic ext_pin_first_wide_timer_oe_n_out,
    input wire logic second_wide_toggle_out,
    input wire logic second_wide_toggle_oe_n_out,
    input wire logic byte_toggle_out,
    input wire logic byte_toggle_oe_n_out
);
    // Short aliases
    wire logic xo = ext_pin_first_wide_timer_out;
    wire logic xe = ext_pin_first_wide_timer_oe_n_out;
    wire logic ye = second_wide_toggle_oe_n_out;
    wire logic bo = byte_toggle_out;
    wire logic be = byte_toggle_oe_n_out;
    wire logic [3:0] mw = {wr_in && addr_in == 5'h0A, wr_in && addr_in == 5'h09,
        wr_in && addr_in == 5'h08, wr_in && addr_in == 5'h07};
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    // ****************************************************************
    // Checks
    // ****************************************************************
    rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside read slot");
    irq_read_a: assert property (rd_in && addr_in == 5'h0A |=>
        rdata_out == {1'b0, $past(irq_req_out)}) else $error("flag read wrong");
    irq_sticky_a: assert property (|($past(irq_req_out) & ~irq_req_out) |->
        $past(|irq_ack_in || mw[3])) else $error("flag dropped alone");
    x_mode_a: assert property (mw[0] |=> xe == ($past(wdata_in[1:0]) != 2'b01)
        && (xe || xo == !$past(wdata_in[3]))) else $error("first pin start wrong");
    y_mode_a: assert property (mw[1] |=> ye == !($past(wdata_in[1:0]) == 2'b00
        && $past(wdata_in[5])) && (ye || second_wide_toggle_out == !$past(wdata_in[3])))
        else $error("second pin start wrong");
    b_mode_a: assert property (mw[2] |=> be == !$past(wdata_in[2])
        && (be || bo == !$past(wdata_in[1]))) else $error("byte pin start wrong");
    x_toggle_a: assert property ($changed(xo) && !xe && !$past(wr_in) |->
        ##[0:1] irq_req_out[0]) else $error("first pin toggled alone");
    b_toggle_a: assert property ($changed(bo) && !be && !$past(wr_in) |->
        ##[0:1] (irq_req_out[3:2] != 2'b00)) else $error("byte pin toggled alone");
    // Main scenarios reached
    cover property ($rose(irq_req_out[0]));
    cover property ($rose(irq_req_out[6]));
    cover property ($changed(bo) && !be);
endmodule // ftu_timer_unit_monitor

bind ftu_timer_unit ftu_timer_unit_monitor i_mon (.*);

//--- sim/ftu_timer_unit_tb.sv
// Self-checking bench for the five-timer unit
`timescale 1ns/1ps
module ftu_timer_unit_tb;
    logic ref_clk_in, resetn_in, wr_in, rd_in, run;
    logic [4:0] addr_in;
    logic [7:0] wdata_in, rdata_out, v, h;
    logic [6:0] irq_ack_in, irq_req_out;
    logic special_count_clock_in, ext_pin_first_wide_timer_in, ext_pin_second_wide_timer_in;
    logic ext_pin_first_wide_timer_out, ext_pin_first_wide_timer_oe_n_out, byte_toggle_out;
    logic second_wide_toggle_out, second_wide_toggle_oe_n_out, byte_toggle_oe_n_out;
    logic [31:0] seed;
    int n_fail, n_compared, c;
    ftu_timer_unit i_dut (.*);
    ftu_pin_model i_pins (.ref_clk_in, .run_in(run), .pin_out({special_count_clock_in,
        ext_pin_first_wide_timer_in, ext_pin_second_wide_timer_in}));
    // Clock and watchdog
    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        n_fail++;
        summarize();
    end
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int uf_max(input int n, input int d);
        return (n + 1) * d + 6;
    endfunction
    // Readable bits of each mode register, reserved bits read 0
    function automatic logic [7:0] mode_mask(input logic [4:0] k);
        return (k == 5'h00) ? 8'hFF : ((k == 5'h01) ? 8'hEF : 8'h7F);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    task automatic wait_irq(input int b, input int lim);
        c = 0;
        // Flags are looked at once the edge has settled
        #1;
        while (irq_req_out[b] !== 1'b1 && c < lim) begin
            @(posedge ref_clk_in);
            #1;
            c++;
        end
    endtask
    task automatic summarize();
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Main sequence
    initial begin
        {resetn_in, wr_in, rd_in, run, addr_in, wdata_in, irq_ack_in} = '0;
        seed = 32'hE7A3;
        n_fail = 0;
        n_compared = 0;
        repeat (4) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        #1 chk({rdata_out, 1'b0, irq_req_out}, 16'h0000);
        wr(5'h07, 8'h10);
        wr(5'h00, 8'h34);
        wr(5'h01, 8'h12);
        repeat (40) @(posedge ref_clk_in);
        rd(5'h01, h);
        rd(5'h00, v);
        chk({h, v}, 16'h1234);
        wr(5'h07, 8'h14);
        wr(5'h00, 8'h78);
        wr(5'h01, 8'h56);
        rd(5'h01, h);
        rd(5'h00, v);
        chk({h, v}, 16'h1234);
        // Every divider on both wide timers
        for (int i = 0; i < 8; i++) begin
            wr(i[0] ? 5'h08 : 5'h07, i[0] ? {i[2:1], 6'h00} : {1'b0, i[2:1], 5'h00});
            wr(i[0] ? 5'h02 : 5'h00, 8'h03);
            wr(i[0] ? 5'h03 : 5'h01, 8'h00);
            wr(5'h0A, 8'h00);
            wait_irq(i[0], uf_max(3, 8 << i[2:1]));
            chk(c >= 3 * (8 << i[2:1]) - 4, 1'b1);
            chk(irq_req_out[i[0]], 1'b1);
            rd(i[0] ? 5'h03 : 5'h01, h);
            rd(i[0] ? 5'h02 : 5'h00, v);
            chk({h, v} <= 16'h0003, 1'b1);
        end
        // Byte timers and shared toggle
        wr(5'h09, 8'h04);
        #1 chk({byte_toggle_oe_n_out, byte_toggle_out}, 16'h0001);
        wr(5'h04, 8'h02);
        wr(5'h05, 8'h05);
        wr(5'h06, 8'h05);
        wr(5'h0A, 8'h00);
        wait_irq(2, uf_max(2, 8));
        repeat (2) @(posedge ref_clk_in);
        chk({irq_req_out[2], byte_toggle_out}, 16'h0002);
        wr(5'h09, 8'h0C);
        wr(5'h04, 8'h80);
        rd(5'h04, v);
        chk(v <= 8'h02, 1'b1);
        // Pin edges: event, period, high/low
        wr(5'h07, 8'h02);
        wr(5'h08, 8'h01);
        wr(5'h0A, 8'h00);
        run <= 1'b1;
        wait_irq(5, 100);
        chk(irq_req_out[5], 1'b1);
        wait_irq(6, 100);
        chk(irq_req_out[6], 1'b1);
        wr(5'h08, 8'h03);
        wr(5'h0A, 8'h00);
        wait_irq(6, 100);
        chk(irq_req_out[6], 1'b1);
        // Next edge of either kind comes half a pin period later
        wr(5'h0A, 8'h00);
        wait_irq(6, 100);
        chk(c <= 7, 1'b1);
        run <= 1'b0;
        repeat (8) @(posedge ref_clk_in);
        irq_ack_in <= 7'h20;
        @(posedge ref_clk_in);
        irq_ack_in <= 7'h00;
        #1 chk(irq_req_out[5], 1'b0);
        // Random mode writes, unmapped reads
        repeat (16) begin
            seed = lfsr(seed);
            wr(5'h07 + seed[4:0] % 5'd3, seed[15:8]);
            rd(5'h07 + seed[4:0] % 5'd3, v);
            chk(v, seed[15:8] & mode_mask(seed[4:0] % 5'd3));
            rd({1'b1, seed[19:16]}, v);
            chk(v, 8'h00);
        end
        summarize();
    end
endmodule // ftu_timer_unit_tb
